// [hdl/mfpc_top.sv]
// Multi-function pin control with AHB-Lite register access
// Functional notes
// R1 - Enable off tri-states; bit 15 sets direction
// R2 - Bit 9 picks push-pull or open drain
// R3 - Bits 14:13 pick none, pull-down, pull-up
// R4 - Bit 10 picks inverted or non-inverted pin
// R5 - Bit 12 picks active edge or both edges
// R6 - Bit 11 picks the pad supply domain
// R7 - Input codes 0 to 7 route requests
// R8 - Input codes 8 to 15 route controls
// R9 - Output codes 0 to 4 pick sources
// R10 - Output codes 8 to 15 pick sources
// R11 - Direction chooses input or output code table
// R12 - Debounce periods are cycle-count parameters
`timescale 1ns/1ns
module mfpc_top import mfpc_pkg::*; #(
  parameter logic [DEB_W-1:0] SHORT_CYC = DEB_W'(DEB_SHORT_CYC),
  parameter logic [DEB_W-1:0] LONG_CYC = DEB_W'(DEB_LONG_CYC)
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Pad
  input wire logic pad_i,
  output logic pad_o,
  output logic pad_oe_o,
  output logic pull_up_o,
  output logic pull_down_o,
  output logic supply_alt_o,
  // Internal sources for output functions
  input wire logic osc_32k_i,
  input wire logic on_state_i,
  input wire logic sleep_state_i,
  input wire logic pwr_change_i,
  input wire logic [1:0] vscale_done_i,
  input wire logic [1:0] ext_pwr_en_i,
  input wire logic system_supply_good_i,
  input wire logic converter_power_good_i,
  input wire logic clk_2m_i,
  input wire logic aux_reset_i,
  // Routed input functions
  output logic gpio_level_o,
  output logic pin_event_o,
  output logic power_onoff_req_o,
  output logic sleep_wake_req_o,
  output logic sleep_req_o,
  output logic power_on_req_o,
  output logic watchdog_reset_o,
  output logic [1:0] voltage_scale_request_o,
  output logic [1:0] hw_enable_o,
  output logic [1:0] hw_control_o
);
  mfpc_bus_type bus_state;
  logic [31:0] wr_addr;
  logic [15:0] ctrl;
  logic out_level;
  logic pin_direction;
  logic [1:0] pull_select;
  logic edge_mode;
  logic supply_domain_select;
  logic polarity_select;
  logic open_drain_select;
  logic pin_enable;
  logic [3:0] pin_function;
  logic addr_take;
  logic pad_sync;
  logic osc_sync;
  logic clk2m_sync;
  logic long_deb;
  logic deb_level;
  logic active_level;
  logic active_prev;
  logic in_active;
  logic next_src;
  logic next_pad;
  logic next_oe;
  logic [31:0] next_rdata;

  // Control fields
  assign pin_direction = ctrl[DIR_BIT];
  assign pull_select = ctrl[PULL_HI:PULL_LO];
  assign edge_mode = ctrl[EDGE_BIT];
  assign supply_domain_select = ctrl[SUPPLY_BIT];
  assign polarity_select = ctrl[POL_BIT];
  assign open_drain_select = ctrl[OD_BIT];
  assign pin_enable = ctrl[ENA_BIT];
  assign pin_function = ctrl[FN_HI:0];
  assign addr_take = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ);
  assign in_active = pin_enable && pin_direction; // R11

  // Bus slave sequencing: one-cycle address phase, zero-wait data phase
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      bus_state <= MFPC_BUS_IDLE;
      wr_addr <= 32'h0000_0000;
    end else begin
      case (bus_state)
        MFPC_BUS_IDLE, MFPC_BUS_WRITE: begin
          if (addr_take && hwrite_i) begin
            bus_state <= MFPC_BUS_WRITE;
            wr_addr <= haddr_i;
          end else begin
            bus_state <= MFPC_BUS_IDLE;
          end
        end
        default: begin
          bus_state <= MFPC_BUS_IDLE;
        end
      endcase
    end
  end

  // Register writes land in the data phase
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ctrl <= CTRL_RESET;
      out_level <= 1'b0;
    end else if (bus_state == MFPC_BUS_WRITE) begin
      if (wr_addr == CTRL_ADDR) begin
        ctrl <= hwdata_i[15:0] & CTRL_MASK;
      end
      if (wr_addr == DATA_ADDR) begin
        out_level <= hwdata_i[0];
      end
    end
  end

  // Read data prepared at the address phase
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (haddr_i == CTRL_ADDR) begin
      next_rdata = {16'h0000, ctrl};
    end else if (haddr_i == DATA_ADDR) begin
      next_rdata = {31'h0000_0000, out_level};
    end else if (haddr_i == STAT_ADDR) begin
      next_rdata = {30'h0000_0000, pad_sync, active_level};
    end
  end

  // Bus answer registers; always ready and OKAY
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      if (addr_take && !hwrite_i) begin
        hrdata_o <= next_rdata;
      end
    end
  end

  // Pin and foreign clock inputs enter through synchronisers
  mfpc_sync u_pad_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .async_i(pad_i),
    .level_o(pad_sync)
  );
  mfpc_sync u_osc_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .async_i(osc_32k_i),
    .level_o(osc_sync)
  );
  mfpc_sync u_clk2m_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .async_i(clk_2m_i),
    .level_o(clk2m_sync)
  );

  // Long period for the functions that ask for it
  assign long_deb = (pin_function == FI_GPIO_LONG) || (pin_function == FI_SLEEP_WAKE_LONG) ||
                    (pin_function == FI_HWCTL1_LONG) || (pin_function == FI_HWCTL2_LONG);
  mfpc_debounce #(
    .SHORT_CYC(SHORT_CYC),
    .LONG_CYC(LONG_CYC)
  ) u_debounce (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .long_i(long_deb),
    .level_i(pad_sync),
    .stable_o(deb_level)
  );

  // Asserted level after polarity
  assign active_level = deb_level ^ ~polarity_select; // R4

  // Output source selection by function code
  always_comb begin
    next_src = 1'b0;
    case (pin_function)
      FO_GPIO: next_src = out_level; // R9
      FO_OSC32K: next_src = osc_sync; // R9
      FO_ON_STATE: next_src = on_state_i; // R9
      FO_SLEEP_STATE: next_src = sleep_state_i; // R9
      FO_PWR_CHANGE: next_src = pwr_change_i; // R9
      FO_VS_DONE1: next_src = vscale_done_i[0]; // R10
      FO_VS_DONE2: next_src = vscale_done_i[1]; // R10
      FO_EXT_EN1: next_src = ext_pwr_en_i[0]; // R10
      FO_EXT_EN2: next_src = ext_pwr_en_i[1]; // R10
      FO_SYS_GOOD: next_src = system_supply_good_i; // R10
      FO_CONV_GOOD: next_src = converter_power_good_i; // R10
      FO_CLK2M: next_src = clk2m_sync; // R10
      FO_AUX_RESET: next_src = aux_reset_i; // R10
      default: next_src = 1'b0;
    endcase
  end

  // Pad drive: tri-state, push-pull or open drain
  always_comb begin
    next_pad = 1'b0;
    next_oe = 1'b0;
    if (pin_enable && !pin_direction) begin // R1
      if (open_drain_select) begin
        next_oe = ~(next_src ^ ~polarity_select); // R2
      end else begin
        next_pad = next_src ^ ~polarity_select; // R4
        next_oe = 1'b1;
      end
    end
  end

  // Pad output registers
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pad_o <= 1'b0;
      pad_oe_o <= 1'b0;
      pull_up_o <= 1'b0;
      pull_down_o <= 1'b0;
      supply_alt_o <= 1'b0;
    end else begin
      pad_o <= next_pad;
      pad_oe_o <= next_oe;
      pull_up_o <= pin_enable && (pull_select == PULL_UP); // R3
      pull_down_o <= pin_enable && (pull_select == PULL_DOWN); // R3
      supply_alt_o <= supply_domain_select; // R6
    end
  end

  // Input function routing and edge events
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      active_prev <= 1'b0;
      gpio_level_o <= 1'b0;
      pin_event_o <= 1'b0;
      power_onoff_req_o <= 1'b0;
      sleep_wake_req_o <= 1'b0;
      sleep_req_o <= 1'b0;
      power_on_req_o <= 1'b0;
      watchdog_reset_o <= 1'b0;
      voltage_scale_request_o <= 2'h0;
      hw_enable_o <= 2'h0;
      hw_control_o <= 2'h0;
    end else begin
      active_prev <= active_level;
      pin_event_o <= in_active && (active_level != active_prev) &&
                     (edge_mode || active_level); // R5
      gpio_level_o <= in_active &&
                      ((pin_function == FI_GPIO_LONG) || (pin_function == FI_GPIO)) &&
                      active_level; // R7
      power_onoff_req_o <= in_active && (pin_function == FI_ONOFF) && active_level; // R7
      sleep_wake_req_o <= in_active && active_level &&
                          ((pin_function == FI_SLEEP_WAKE) ||
                           (pin_function == FI_SLEEP_WAKE_LONG)); // R7
      sleep_req_o <= in_active && (pin_function == FI_SLEEP) && active_level; // R7
      power_on_req_o <= in_active && (pin_function == FI_POWER_ON) && active_level; // R7
      watchdog_reset_o <= in_active && (pin_function == FI_WATCHDOG) && active_level; // R7
      voltage_scale_request_o[0] <= in_active && (pin_function == FI_VSCALE1) &&
                                    active_level; // R8
      voltage_scale_request_o[1] <= in_active && (pin_function == FI_VSCALE2) &&
                                    active_level; // R8
      hw_enable_o[0] <= in_active && (pin_function == FI_HWEN1) && active_level; // R8
      hw_enable_o[1] <= in_active && (pin_function == FI_HWEN2) && active_level; // R8
      hw_control_o[0] <= in_active && active_level &&
                         ((pin_function == FI_HWCTL1) || (pin_function == FI_HWCTL1_LONG)); // R8
      hw_control_o[1] <= in_active && active_level &&
                         ((pin_function == FI_HWCTL2) || (pin_function == FI_HWCTL2_LONG)); // R8
    end
  end

  // Checks on pad drive and routing
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  chk_tristate_when_off: assert property ( // R1
    $past(!pin_enable || pin_direction) |-> !pad_oe_o)
    else $error("pad driven while disabled or input");
  chk_open_drain_low: assert property ( // R2
    $past(pin_enable && !pin_direction && open_drain_select) |-> !pad_o)
    else $error("open drain pad drove high");
  chk_pull_reserved: assert property ( // R3
    $past(pull_select) == 2'h3 |-> !pull_up_o && !pull_down_o)
    else $error("reserved pull code enabled a resistor");
  chk_gpio_polarity: assert property ( // R4
    $past(pin_enable && !pin_direction && !open_drain_select && pin_function == FO_GPIO)
    |-> pad_o == ($past(out_level) ^ ~$past(polarity_select)))
    else $error("gpio output level or polarity wrong");
  chk_single_edge: assert property ( // R5
    $past(!edge_mode) && $past(active_prev) && $past(!active_level) |-> !pin_event_o)
    else $error("event on inactive edge in single edge mode");
  chk_supply_select: assert property ( // R6
    ##1 supply_alt_o == $past(supply_domain_select))
    else $error("supply select does not follow control");
  chk_watchdog_route: assert property ( // R7
    $past(in_active && pin_function == FI_WATCHDOG) |-> watchdog_reset_o == $past(active_level))
    else $error("watchdog input not routed");
  chk_hwctl_route: assert property ( // R8
    $past(in_active && (pin_function == FI_HWCTL1 || pin_function == FI_HWCTL1_LONG))
    |-> hw_control_o[0] == $past(active_level))
    else $error("hardware control input not routed");
  chk_osc_route: assert property ( // R9
    $past(pin_enable && !pin_direction && !open_drain_select && pin_function == FO_OSC32K)
    |-> pad_o == ($past(osc_sync) ^ ~$past(polarity_select)))
    else $error("oscillator output not routed");
  chk_output_no_request: assert property ( // R11
    $past(!pin_direction) |-> !power_on_req_o && !hw_enable_o[0] && !pin_event_o)
    else $error("input function active while pin is output");
  chk_bus_ready: assert property (
    hreadyout_o && !hresp_o)
    else $error("bus slave not ready or not OKAY");
endmodule // mfpc_top

// [hdl/mfpc_pkg.sv]
// Constants shared by the multi-function pin control block
package mfpc_pkg;
  // Register indices and byte addresses
  localparam logic [31:0] CTRL_INDEX = 32'h0000_4043;
  localparam logic [31:0] CTRL_ADDR = 32'h0001_010C;
  localparam logic [31:0] DATA_ADDR = 32'h0001_0200;
  localparam logic [31:0] STAT_ADDR = 32'h0001_0204;
  // Control field positions
  localparam int DIR_BIT = 15;
  localparam int PULL_HI = 14;
  localparam int PULL_LO = 13;
  localparam int EDGE_BIT = 12;
  localparam int SUPPLY_BIT = 11;
  localparam int POL_BIT = 10;
  localparam int OD_BIT = 9;
  localparam int ENA_BIT = 7;
  localparam int FN_HI = 3;
  // Reset value and writable bits of the control word
  localparam logic [15:0] CTRL_RESET = 16'hA400;
  localparam logic [15:0] CTRL_MASK = 16'hFE8F;
  // Pull resistor codes
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP = 2'h2;
  // Input function codes
  localparam logic [3:0] FI_GPIO_LONG = 4'h0;
  localparam logic [3:0] FI_GPIO = 4'h1;
  localparam logic [3:0] FI_ONOFF = 4'h2;
  localparam logic [3:0] FI_SLEEP_WAKE = 4'h3;
  localparam logic [3:0] FI_SLEEP_WAKE_LONG = 4'h4;
  localparam logic [3:0] FI_SLEEP = 4'h5;
  localparam logic [3:0] FI_POWER_ON = 4'h6;
  localparam logic [3:0] FI_WATCHDOG = 4'h7;
  localparam logic [3:0] FI_VSCALE1 = 4'h8;
  localparam logic [3:0] FI_VSCALE2 = 4'h9;
  localparam logic [3:0] FI_HWEN1 = 4'hA;
  localparam logic [3:0] FI_HWEN2 = 4'hB;
  localparam logic [3:0] FI_HWCTL1 = 4'hC;
  localparam logic [3:0] FI_HWCTL2 = 4'hD;
  localparam logic [3:0] FI_HWCTL1_LONG = 4'hE;
  localparam logic [3:0] FI_HWCTL2_LONG = 4'hF;
  // Output function codes
  localparam logic [3:0] FO_GPIO = 4'h0;
  localparam logic [3:0] FO_OSC32K = 4'h1;
  localparam logic [3:0] FO_ON_STATE = 4'h2;
  localparam logic [3:0] FO_SLEEP_STATE = 4'h3;
  localparam logic [3:0] FO_PWR_CHANGE = 4'h4;
  localparam logic [3:0] FO_VS_DONE1 = 4'h8;
  localparam logic [3:0] FO_VS_DONE2 = 4'h9;
  localparam logic [3:0] FO_EXT_EN1 = 4'hA;
  localparam logic [3:0] FO_EXT_EN2 = 4'hB;
  localparam logic [3:0] FO_SYS_GOOD = 4'hC;
  localparam logic [3:0] FO_CONV_GOOD = 4'hD;
  localparam logic [3:0] FO_CLK2M = 4'hE;
  localparam logic [3:0] FO_AUX_RESET = 4'hF;
  // Debounce timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int DEB_SHORT_US = 50;
  localparam int DEB_LONG_US = 20000;
  localparam int DEB_SHORT_CYC = (DEB_SHORT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEB_LONG_CYC = (DEB_LONG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEB_W = 22;
  // Bus transfer type codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // Bus slave states
  typedef enum logic [1:0] {
    MFPC_BUS_IDLE = 2'b01,
    MFPC_BUS_WRITE = 2'b10
  } mfpc_bus_type;
endpackage

// [hdl/mfpc_sync.sv]
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ns
module mfpc_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Asynchronous level in, filtered level out
  input wire logic async_i,
  output logic level_o
);
  logic s1;
  logic s2;
  logic s3;

  // Shift chain; only the second stage reads the first
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Accept a change once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      level_o <= 1'b0;
    end else if (s2 == s3) begin
      level_o <= s3;
    end
  end
endmodule // mfpc_sync

// [hdl/mfpc_debounce.sv]
// Debounce filter with short and long hold periods
`timescale 1ns/1ns
module mfpc_debounce import mfpc_pkg::*; #(
  parameter logic [DEB_W-1:0] SHORT_CYC = DEB_W'(DEB_SHORT_CYC),
  parameter logic [DEB_W-1:0] LONG_CYC = DEB_W'(DEB_LONG_CYC)
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Filter control and data
  input wire logic long_i,
  input wire logic level_i,
  output logic stable_o
);
  logic [DEB_W-1:0] count;
  logic [DEB_W-1:0] limit;

  assign limit = long_i ? LONG_CYC : SHORT_CYC;

  // Level must hold for the whole period before it is accepted
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      count <= '0;
      stable_o <= 1'b0;
    end else if (level_i == stable_o) begin
      count <= '0;
    end else if (count >= limit - DEB_W'(1)) begin // R12
      count <= '0;
      stable_o <= level_i;
    end else begin
      count <= count + DEB_W'(1);
    end
  end

  chk_debounce_hold: assert property ( // R12
    @(posedge clk_i) disable iff (!nrst_i)
    (stable_o != $past(stable_o)) |-> ($past(count) >= $past(limit) - DEB_W'(1)))
    else $error("debounced level changed before its period elapsed");
endmodule // mfpc_debounce

// [bench/mfpc_pin_model.sv]
// External circuit on the pin: resolves the wire level seen by the pad input
`timescale 1ns/1ns
module mfpc_pin_model (
  // Clock
  input wire logic clk_i,
  // Pad controls from the device
  input wire logic pad_level_i,
  input wire logic pad_oe_i,
  input wire logic pull_up_i,
  input wire logic pull_down_i,
  // Far-side driver commanded by the bench
  input wire logic drive_en_i,
  input wire logic drive_lvl_i,
  // Resolved wire level
  output logic level_o
);
  logic float_q;
  // A floating wire keeps changing so a stale level never passes
  initial float_q = 1'b0;
  always @(posedge clk_i) begin
    float_q <= ~float_q;
  end
  // Device drive wins, then the far side, then the resistors
  always_comb begin
    if (pad_oe_i) begin
      level_o = pad_level_i;
    end else if (drive_en_i) begin
      level_o = drive_lvl_i;
    end else if (pull_up_i) begin
      level_o = 1'b1;
    end else if (pull_down_i) begin
      level_o = 1'b0;
    end else begin
      level_o = float_q;
    end
  end
endmodule // mfpc_pin_model

// [bench/multi_function_pin_control_test.sv]
// Self-checking bench for the multi-function pin control block
`timescale 1ns/1ns
module multi_function_pin_control_test import mfpc_pkg::*;;
  logic clk_i, nrst_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
  logic [1:0] htrans_i, vsr, hwen, hwctl;
  logic pad_i, pad_o, pad_oe_o, pull_up_o, pull_down_o, supply_alt_o;
  logic gpio, evt, onoff, swake, slp, pon, wdog, drv_en, drv_lvl;
  logic [15:0] src;
  logic [11:0] routed;
  int err_count, comparisons, n;
  // Routed input index per function code
  localparam int IN_BIT [16] = '{0, 0, 1, 2, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 10, 11};
  localparam logic [31:0] PW [6] = '{32'hA480, 32'hC480, 32'h8480, 32'h8C80, 32'hE480, 32'hA400};
  localparam logic [31:0] PE [6] = '{32'h4, 32'h8, 32'h0, 32'h2, 32'h0, 32'h0};
  localparam logic [31:0] OW [4] = '{32'h0080, 32'h0680, 32'h0680, 32'h0280};
  localparam logic [31:0] OD [4] = '{32'h1, 32'h1, 32'h0, 32'h1};
  localparam logic [31:0] OE [4] = '{32'h2, 32'h0, 32'h2, 32'h2};
  localparam logic [31:0] EW [4] = '{32'h8481, 32'h8081, 32'h9481, 32'h9081};
  localparam logic [31:0] ER [4] = '{32'h1, 32'h0, 32'h1, 32'h1};
  localparam logic [31:0] EF [4] = '{32'h0, 32'h1, 32'h1, 32'h1};
  assign routed = {hwctl, hwen, vsr, wdog, pon, slp, swake, onoff, gpio};
  // Device with short debounce counts for simulation
  mfpc_top #(.SHORT_CYC(22'h000004), .LONG_CYC(22'h00000A)) i_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .pad_i(pad_i), .pad_o(pad_o), .pad_oe_o(pad_oe_o),
    .pull_up_o(pull_up_o), .pull_down_o(pull_down_o), .supply_alt_o(supply_alt_o),
    .osc_32k_i(src[1]), .on_state_i(src[2]), .sleep_state_i(src[3]),
    .pwr_change_i(src[4]), .vscale_done_i(src[9:8]), .ext_pwr_en_i(src[11:10]),
    .system_supply_good_i(src[12]), .converter_power_good_i(src[13]),
    .clk_2m_i(src[14]), .aux_reset_i(src[15]), .gpio_level_o(gpio),
    .pin_event_o(evt), .power_onoff_req_o(onoff), .sleep_wake_req_o(swake),
    .sleep_req_o(slp), .power_on_req_o(pon), .watchdog_reset_o(wdog),
    .voltage_scale_request_o(vsr), .hw_enable_o(hwen), .hw_control_o(hwctl)
  );
  // Far side of the pin
  mfpc_pin_model i_pin (
    .clk_i(clk_i), .pad_level_i(pad_o), .pad_oe_i(pad_oe_o), .pull_up_i(pull_up_o),
    .pull_down_i(pull_down_o), .drive_en_i(drv_en), .drive_lvl_i(drv_lvl), .level_o(pad_i)
  );
  // 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Print counts and verdict, then stop
  task automatic give_verdict();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Bounded wait for hready sampled high at a rising edge
  task automatic wait_ready();
    int k;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (hreadyout_o !== 1'b1 && k < 20);
    if (hreadyout_o !== 1'b1) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, hreadyout_o, 1'b1);
      give_verdict();
    end
  endtask
  task automatic bus_xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    haddr_i <= a;
    hwrite_i <= w;
    htrans_i <= HTRANS_NONSEQ;
    wait_ready();
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    wait_ready();
    rd = hrdata_o;
  endtask
  task automatic bus_write(input logic [31:0] a, input logic [31:0] d);
    bus_xfer(1'b1, a, d);
  endtask
  task automatic bus_read(input logic [31:0] a);
    bus_xfer(1'b0, a, 32'h0);
    check({31'h0, hresp_o}, 32'h0);
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask
  task automatic drive(input logic l);
    @(posedge clk_i);
    drv_lvl <= l;
  endtask
  task automatic count_events(input logic l);
    drive(l);
    n = 0;
    repeat (30) begin
      @(posedge clk_i);
      #1;
      if (evt === 1'b1) n++;
    end
  endtask
  // Main sequence
  initial begin
    nrst_i = 1'b0;
    hsel_i = 1'b0;
    haddr_i = 32'h0;
    htrans_i = 2'h0;
    hwrite_i = 1'b0;
    hwdata_i = 32'h0;
    src = 16'h0;
    drv_en = 1'b1;
    drv_lvl = 1'b0;
    err_count = 0;
    comparisons = 0;
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    settle(1);
    check({29'h0, pad_oe_o, pull_down_o, supply_alt_o}, 32'h0);
    bus_read(CTRL_ADDR);
    check(rd, 32'h0000A400);
    bus_write(32'h0001_0300, 32'hFFFF_FFFF);
    bus_read(32'h0001_0300);
    check(rd, 32'h0);
    bus_write(CTRL_ADDR, 32'hFFFF_FFFF);
    bus_read(CTRL_ADDR);
    check(rd, 32'h0000FE8F);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      bus_write(CTRL_ADDR, PW[i]);
      settle(4);
      check({28'h0, pull_up_o, pull_down_o, supply_alt_o, pad_oe_o}, PE[i]);
    end
    // Released far side: the resistors alone set the wire level
    drv_en <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      bus_write(CTRL_ADDR, (i == 1) ? 32'hC481 : 32'hA481);
      settle(12);
      bus_read(STAT_ADDR);
      check(rd, (i == 1) ? 32'h3 : 32'h0);
    end
    drv_en <= 1'b1;
    $display("test pad setup done");
    drive(1'b1);
    for (int c = 0; c < 16; c++) begin
      for (int l = 0; l < 2; l++) begin
        bus_write(DATA_ADDR, (c == 0) ? 32'(l) : 32'(1 - l));
        src <= (l == 1) ? (16'h0001 << c) : ~(16'h0001 << c);
        bus_write(CTRL_ADDR, 32'h0480 | 32'(c));
        settle(8);
        check({30'h0, pad_oe_o, pad_o}, {30'h0, 1'b1, (c >= 5 && c <= 7) ? 1'b0 : l[0]});
        check({20'h0, routed}, 32'h0);
      end
    end
    for (int i = 0; i < 4; i++) begin
      bus_write(DATA_ADDR, OD[i]);
      bus_write(CTRL_ADDR, OW[i]);
      settle(6);
      check({30'h0, pad_oe_o, pad_o}, OE[i]);
    end
    $display("test output functions done");
    src <= 16'hFFFF;
    for (int c = 0; c < 16; c++) begin
      drive(1'b0);
      bus_write(CTRL_ADDR, 32'h8480 | 32'(c));
      settle(25);
      drive(1'b1);
      settle(12);
      if (c < 2) check({31'h0, gpio}, 32'(c));
      settle(13);
      check({20'h0, routed}, 32'h1 << IN_BIT[c]);
      check({31'h0, pad_oe_o}, 32'h0);
    end
    bus_read(STAT_ADDR);
    check(rd, 32'h3);
    bus_write(CTRL_ADDR, 32'h8401);
    settle(6);
    check({20'h0, routed}, 32'h0);
    $display("test input functions done");
    for (int i = 0; i < 4; i++) begin
      drive(1'b0);
      bus_write(CTRL_ADDR, EW[i]);
      settle(25);
      check({31'h0, gpio}, {31'h0, ~EW[i][10]});
      count_events(1'b1);
      check(32'(n), ER[i]);
      count_events(1'b0);
      check(32'(n), EF[i]);
    end
    $display("test edges done");
    give_verdict();
  end
endmodule // multi_function_pin_control_test
